//--- core/lfc_host.sv
// host end: request buffer and bus cycle generator
// assumes requests arrive on clk; one response per request, in order
module lfc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lfc_fifo_st_t;

  lfc_fifo_st_t st_r;
  lfc_fifo_st_t st_nxt;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign in_ready  = (st_r.wp - st_r.rp) != (AW+1)'(D);
  assign out_valid = st_r.wp != st_r.rp;
  assign out_data  = mem[st_r.rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + (AW+1)'(1);
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem[st_r.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

module lfc_host (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bus
  lfc_if.host              lpc,
  // requests
  input  wire logic        req_valid,
  output      logic        req_ready,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  // responses
  output      logic        rsp_valid,
  output      logic [7:0]  rsp_data,
  output      logic        rsp_err
);
  typedef struct packed {
    lfc_pkg::lfc_hph_t ph;
    logic [3:0]        cnt;
    logic              wr;
    logic [31:0]       addr;
    logic [7:0]        data;
    logic              frame_n;
    logic [3:0]        lad_o;
    logic              lad_oe;
    logic              rsp_valid;
    logic              rsp_err;
  } lfc_host_st_t;

  lfc_host_st_t                 st_r;
  lfc_host_st_t                 st_nxt;
  logic                         q_valid;
  logic                         q_ready;
  logic [lfc_pkg::REQ_W-1:0]    q_data;

  // the engine only drains while idle, so a slow bus fills the buffer
  lfc_fifo #(.W(lfc_pkg::REQ_W), .D(lfc_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_addr, req_wdata}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  assign q_ready = st_r.ph == lfc_pkg::HP_IDLE;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.rsp_err = 1'b0;
    case (st_r.ph)
      lfc_pkg::HP_IDLE: begin
        if (q_valid) begin
          {st_nxt.wr, st_nxt.addr, st_nxt.data} = q_data;
          st_nxt.frame_n = 1'b0;
          st_nxt.lad_o = lfc_pkg::NIB_START;
          st_nxt.lad_oe = 1'b1;
          st_nxt.ph = lfc_pkg::HP_KIND;
        end
      end
      lfc_pkg::HP_KIND: begin
        st_nxt.frame_n = 1'b1;
        st_nxt.lad_o = {lfc_pkg::KIND_MEM, st_r.wr, 1'b0};
        st_nxt.cnt = 4'h0;
        st_nxt.ph = lfc_pkg::HP_ADDR;
      end
      lfc_pkg::HP_ADDR: begin
        st_nxt.lad_o = st_r.addr[31:28];
        st_nxt.addr = {st_r.addr[27:0], 4'h0};
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (st_r.cnt[2:0] == lfc_pkg::ADDR_LAST) begin
          st_nxt.cnt = 4'h0;
          st_nxt.ph = st_r.wr ? lfc_pkg::HP_WDAT : lfc_pkg::HP_TAR;
        end
      end
      lfc_pkg::HP_WDAT: begin
        st_nxt.lad_o = st_r.data[3:0];
        st_nxt.data = {4'h0, st_r.data[7:4]};
        st_nxt.cnt = 4'h1;
        if (st_r.cnt != 4'h0) begin
          st_nxt.ph = lfc_pkg::HP_TAR;
        end
      end
      lfc_pkg::HP_TAR: begin
        st_nxt.lad_o = lfc_pkg::NIB_TAR;
        st_nxt.ph = lfc_pkg::HP_REL;
      end
      lfc_pkg::HP_REL: begin
        st_nxt.lad_oe = 1'b0;
        st_nxt.cnt = 4'h0;
        st_nxt.ph = lfc_pkg::HP_SYNC;
      end
      lfc_pkg::HP_SYNC: begin
        st_nxt.cnt = st_r.cnt + 4'h1;
        if (lpc.lad == lfc_pkg::NIB_READY) begin
          st_nxt.cnt = 4'h0;
          st_nxt.rsp_valid = st_r.wr;
          st_nxt.ph = st_r.wr ? lfc_pkg::HP_END : lfc_pkg::HP_RDAT;
        end else if (st_r.cnt == lfc_pkg::SYNC_TMO) begin
          // no sync from the target: report and give the bus back
          st_nxt.rsp_err = 1'b1;
          st_nxt.rsp_valid = 1'b1;
          st_nxt.ph = lfc_pkg::HP_IDLE;
        end
      end
      lfc_pkg::HP_RDAT: begin
        st_nxt.data = {lpc.lad, st_r.data[7:4]};
        st_nxt.cnt = 4'h1;
        if (st_r.cnt != 4'h0) begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.cnt = 4'h0;
          st_nxt.ph = lfc_pkg::HP_END;
        end
      end
      lfc_pkg::HP_END: begin
        st_nxt.cnt = 4'h1;
        if (st_r.cnt != 4'h0) begin
          st_nxt.ph = lfc_pkg::HP_IDLE;
        end
      end
      default: begin
        st_nxt.ph = lfc_pkg::HP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.frame_n <= 1'b1;
      st_r.lad_o <= lfc_pkg::NIB_TAR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lpc.lframe_n    = st_r.frame_n;
  assign lpc.host_lad_o  = st_r.lad_o;
  assign lpc.host_lad_oe = st_r.lad_oe;
  assign rsp_valid       = st_r.rsp_valid;
  assign rsp_data        = st_r.data;
  assign rsp_err         = st_r.rsp_err;
endmodule

//--- core/lfc_pkg.sv
// shared constants and types for both ends of the flash bus link
// assumes one clock, clk at 200 MHz, synchronous active-high reset
package lfc_pkg;
  // ----------------------------------------------------------------
  // bus nibbles
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_START = 4'h0;
  localparam logic [3:0] NIB_TAR   = 4'hf;
  localparam logic [3:0] NIB_WAIT  = 4'h5;
  localparam logic [3:0] NIB_READY = 4'h0;
  localparam logic [1:0] KIND_MEM  = 2'h1;
  localparam logic [2:0] ADDR_LAST = 3'h7;
  localparam logic [3:0] SYNC_TMO  = 4'hf;

  // ----------------------------------------------------------------
  // command codes (plain defaults)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RD_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RD_SIG    = 8'h90;
  localparam logic [7:0] CMD_PROG      = 8'h40;

  // ----------------------------------------------------------------
  // host request buffer
  // ----------------------------------------------------------------
  localparam int REQ_W      = 41;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_SIG} lfc_mode_t;
  typedef enum logic [3:0] {
    DP_IDLE, DP_KIND, DP_ADDR, DP_WDAT, DP_TAR, DP_OWN, DP_WAIT, DP_SYNC,
    DP_RDAT, DP_END
  } lfc_dph_t;
  typedef enum logic [3:0] {
    HP_IDLE, HP_KIND, HP_ADDR, HP_WDAT, HP_TAR, HP_REL, HP_SYNC, HP_RDAT,
    HP_END
  } lfc_hph_t;
endpackage

//--- core/lfc_if.sv
// the shared 4-bit bus between host and flash target
// assumes lad floats high (pull-ups) when neither end drives it
interface lfc_if;
  logic       lframe_n;
  logic [3:0] host_lad_o;
  logic       host_lad_oe;
  logic [3:0] dev_lad_o;
  logic       dev_lad_oe;
  logic [3:0] lad;

  assign lad = host_lad_oe ? host_lad_o : (dev_lad_oe ? dev_lad_o : 4'hf);

  modport dev  (input lframe_n, input lad, output dev_lad_o,
                output dev_lad_oe);
  modport host (output lframe_n, output host_lad_o, output host_lad_oe,
                input lad);
endinterface

//--- core/lfc_dev.sv
// flash target end: bus cycle decode and command interface
// assumes array data, status byte and busy come from outside, stable
// for several clocks after the address phase
module lfc_dev #(
  parameter logic [7:0] MFR_CODE = 8'ha5,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5a   // arbitrary value
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bus
  lfc_if.dev               lpc,
  // array and controller side
  output      logic [31:0] arr_addr,
  input  wire logic [7:0]  arr_rdata,
  input  wire logic [7:0]  status_byte,
  input  wire logic        pe_busy,
  output      logic        prog_start,
  output      logic [31:0] prog_addr,
  output      logic [7:0]  prog_data
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lfc_pkg::lfc_dph_t  ph;
    logic [2:0]         cnt;
    logic               wr;
    logic [31:0]        addr;
    logic [7:0]         data;
    logic [3:0]         lad_o;
    logic               lad_oe;
    lfc_pkg::lfc_mode_t mode;
    logic               setup;
    logic               prog_start;
    logic [31:0]        prog_addr;
    logic [7:0]         prog_data;
  } lfc_dev_st_t;

  lfc_dev_st_t st_r;
  lfc_dev_st_t st_nxt;
  logic [7:0]  cmd;
  logic [7:0]  rbyte;

  function automatic logic [7:0] pick(lfc_pkg::lfc_mode_t m,
                                      logic a0, logic [7:0] arr,
                                      logic [7:0] stat);
    case (m)
      lfc_pkg::MODE_ARRAY:  pick = arr;
      lfc_pkg::MODE_STATUS: pick = stat;
      default:              pick = a0 ? DEV_CODE : MFR_CODE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prog_start = 1'b0;
    cmd = {lpc.lad, st_r.data[7:4]};
    rbyte = pick(st_r.mode, st_r.addr[0], arr_rdata, status_byte);
    if (!lpc.lframe_n) begin
      // a new frame always wins; any cycle in flight is dropped
      st_nxt.lad_oe = 1'b0;
      st_nxt.ph = (lpc.lad == lfc_pkg::NIB_START) ?
                  lfc_pkg::DP_KIND : lfc_pkg::DP_IDLE;
    end else begin
      case (st_r.ph)
        lfc_pkg::DP_IDLE: begin
          st_nxt.lad_oe = 1'b0;
        end
        lfc_pkg::DP_KIND: begin
          st_nxt.wr = lpc.lad[1];
          st_nxt.cnt = 3'h0;
          if (lpc.lad[3:2] == lfc_pkg::KIND_MEM &&
              (lpc.lad[1] || !lpc.lad[0])) begin
            st_nxt.ph = lfc_pkg::DP_ADDR;
          end else begin
            st_nxt.ph = lfc_pkg::DP_IDLE;
          end
        end
        lfc_pkg::DP_ADDR: begin
          st_nxt.addr = {st_r.addr[27:0], lpc.lad};
          st_nxt.cnt = st_r.cnt + 3'h1;
          if (st_r.cnt == lfc_pkg::ADDR_LAST) begin
            st_nxt.cnt = 3'h0;
            st_nxt.ph = st_r.wr ? lfc_pkg::DP_WDAT : lfc_pkg::DP_TAR;
          end
        end
        lfc_pkg::DP_WDAT: begin
          st_nxt.data = {lpc.lad, st_r.data[7:4]};
          st_nxt.cnt = 3'h1;
          if (st_r.cnt != 3'h0) begin
            st_nxt.ph = lfc_pkg::DP_TAR;
            if (st_r.setup) begin
              st_nxt.setup = 1'b0;
              st_nxt.prog_start = 1'b1;
              st_nxt.prog_addr = st_r.addr;
              st_nxt.prog_data = cmd;
              st_nxt.mode = lfc_pkg::MODE_STATUS;
            end else begin
              case (cmd)
                lfc_pkg::CMD_RD_ARRAY: begin
                  // refused, not queued: host must retry after busy ends
                  if (!pe_busy) begin
                    st_nxt.mode = lfc_pkg::MODE_ARRAY;
                  end
                end
                lfc_pkg::CMD_RD_STATUS: begin
                  st_nxt.mode = lfc_pkg::MODE_STATUS;
                end
                lfc_pkg::CMD_RD_SIG: begin
                  st_nxt.mode = lfc_pkg::MODE_SIG;
                end
                lfc_pkg::CMD_PROG: begin
                  st_nxt.setup = 1'b1;
                end
                default: begin
                end
              endcase
            end
          end
        end
        lfc_pkg::DP_TAR: begin
          // host drives 1111 now; we drive the same value from the next cycle, once it has let go
          st_nxt.lad_oe = 1'b1;
          st_nxt.lad_o = lfc_pkg::NIB_TAR;
          st_nxt.ph = lfc_pkg::DP_OWN;
        end
        lfc_pkg::DP_OWN: begin
          st_nxt.cnt = 3'h0;
          if (st_r.wr) begin
            st_nxt.lad_o = lfc_pkg::NIB_READY;
            st_nxt.ph = lfc_pkg::DP_SYNC;
          end else begin
            st_nxt.lad_o = lfc_pkg::NIB_WAIT;
            st_nxt.ph = lfc_pkg::DP_WAIT;
          end
        end
        lfc_pkg::DP_WAIT: begin
          st_nxt.cnt = 3'h1;
          if (st_r.cnt != 3'h0) begin
            st_nxt.lad_o = lfc_pkg::NIB_READY;
            st_nxt.ph = lfc_pkg::DP_SYNC;
          end
        end
        lfc_pkg::DP_SYNC: begin
          st_nxt.cnt = 3'h0;
          if (st_r.wr) begin
            st_nxt.lad_o = lfc_pkg::NIB_TAR;
            st_nxt.ph = lfc_pkg::DP_END;
          end else begin
            st_nxt.data = rbyte;
            st_nxt.lad_o = rbyte[3:0];
            st_nxt.ph = lfc_pkg::DP_RDAT;
          end
        end
        lfc_pkg::DP_RDAT: begin
          st_nxt.lad_o = st_r.data[7:4];
          st_nxt.ph = lfc_pkg::DP_END;
        end
        lfc_pkg::DP_END: begin
          if (st_r.lad_o == st_r.data[7:4] && !st_r.wr &&
              st_r.cnt == 3'h0) begin
            st_nxt.cnt = 3'h1;
            st_nxt.lad_o = lfc_pkg::NIB_TAR;
          end else begin
            st_nxt.lad_oe = 1'b0;
            st_nxt.ph = lfc_pkg::DP_IDLE;
          end
        end
        default: begin
          st_nxt.ph = lfc_pkg::DP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.mode <= lfc_pkg::MODE_ARRAY;
      st_r.lad_o <= lfc_pkg::NIB_TAR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lpc.dev_lad_o  = st_r.lad_o;
  assign lpc.dev_lad_oe = st_r.lad_oe;
  assign arr_addr       = st_r.addr;
  assign prog_start     = st_r.prog_start;
  assign prog_addr      = st_r.prog_addr;
  assign prog_data      = st_r.prog_data;
endmodule

//--- test/lfc_link_sva.sv
// checker for the wire protocol between the host and flash ends
// assumes it sits beside the interface that joins both design ends
module lfc_link_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // bus
  input wire logic       lframe_n,
  input wire logic [3:0] host_lad_o,
  input wire logic       host_lad_oe,
  input wire logic [3:0] dev_lad_o,
  input wire logic       dev_lad_oe,
  input wire logic [3:0] lad
);
  // ----
  // frame decode
  // ----
  wire logic st = !lframe_n && lad == 4'h0;
  wire logic rk = lframe_n && lad == 4'h4;
  wire logic wk = lframe_n && lad[3:1] == 3'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----
  // read and write frames
  // ----
  a_read_own_tar: assert property (st ##1 rk |-> ##9 !dev_lad_oe
    ##1 dev_lad_oe && dev_lad_o == 4'hf) else $error("read tar");
  a_wait_sync: assert property (st ##1 rk |-> ##11
    (dev_lad_oe && dev_lad_o == 4'h5) [*2]) else $error("wait sync");
  a_ready_sync: assert property (st ##1 rk |-> ##13
    dev_lad_oe && dev_lad_o == 4'h0) else $error("ready sync");
  a_read_end: assert property (st ##1 rk |-> ##16 dev_lad_oe &&
    dev_lad_o == 4'hf ##1 !dev_lad_oe) else $error("read end");
  a_host_tar: assert property (st ##1 rk |-> ##9
    host_lad_oe && host_lad_o == 4'hf) else $error("host tar");
  a_write_sync: assert property (st ##1 wk |-> ##12 dev_lad_oe
    ##1 dev_lad_oe && dev_lad_o == 4'h0) else $error("write sync");
  a_write_end: assert property (st ##1 wk |-> ##14 dev_lad_oe &&
    dev_lad_o == 4'hf ##1 !dev_lad_oe) else $error("write end");
  a_abort_release: assert property (!lframe_n |=> !dev_lad_oe)
    else $error("drive in frame low");
  a_drive_start: assert property ($rose(dev_lad_oe) |->
    $past(st, 11) || $past(st, 13)) else $error("drive without start");
  a_drive_kind: assert property ($rose(dev_lad_oe) |->
    $past(rk, 10) || $past(wk, 12)) else $error("drive on bad kind");
endmodule

//--- test/tb_top.sv
// bench: host and flash ends joined, plus a lone target on a test bus
// assumes clk at 200 MHz and the shared interface from core/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // signals
  // ----
  localparam logic [7:0] MFR  = 8'h6b;  // arbitrary value
  localparam logic [7:0] DEVC = 8'hd4;  // arbitrary value
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        pe_busy = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [7:0]  req_wdata = 8'h0;
  logic [7:0]  stat = 8'h0;
  logic        req_ready, rsp_valid, rsp_err, prog_start, wk, refused;
  logic [7:0]  rsp_data, prog_data, arr_rdata, wd, ed;
  logic [31:0] arr_addr, prog_addr, wa, ea;
  logic [40:0] eq[$], wq[$], ew, gw;
  logic [4:0]  cyc = 5'h0;
  logic [3:0]  n15;
  bit          pend = 0;
  int          err_total = 0, n_checks = 0, mode = 0, epc = 0, pcnt = 0;
  int          drv;
  logic [3:0]  bs[6] = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  logic [3:0]  bk[6] = '{4'h4, 4'h5, 4'hc, 4'h4, 4'h7, 4'h4};
  int          ba[6] = '{0, 0, 0, 0, 0, 14};
  int          bn[6] = '{0, 0, 0, 7, 3, 3};
  lfc_if bus();
  lfc_if bad();
  always #2.5 clk = ~clk;
  assign arr_rdata = arr_addr[7:0] ^ arr_addr[31:24];
  // ----
  // instances
  // ----
  lfc_host lfc_host_i (.clk(clk), .sys_rst(sys_rst), .lpc(bus.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err));
  lfc_dev #(.MFR_CODE(MFR), .DEV_CODE(DEVC)) lfc_dev_i (.clk(clk),
    .sys_rst(sys_rst), .lpc(bus.dev), .arr_addr(arr_addr),
    .arr_rdata(arr_rdata), .status_byte(stat), .pe_busy(pe_busy),
    .prog_start(prog_start), .prog_addr(prog_addr), .prog_data(prog_data));
  lfc_dev lfc_dev_b_i (.clk(clk), .sys_rst(sys_rst), .lpc(bad.dev),
    .arr_addr(), .arr_rdata(8'h00), .status_byte(stat), .pe_busy(pe_busy),
    .prog_start(), .prog_addr(), .prog_data());
  lfc_link_sva lfc_link_sva_i (.clk(clk), .sys_rst(sys_rst),
    .lframe_n(bus.lframe_n), .host_lad_o(bus.host_lad_o),
    .host_lad_oe(bus.host_lad_oe), .dev_lad_o(bus.dev_lad_o),
    .dev_lad_oe(bus.dev_lad_oe), .lad(bus.lad));
  // ----
  // wire monitor: fields as seen on the bus, cycle number is cyc+1
  // ----
  always @(posedge clk) begin
    if (prog_start === 1'b1) pcnt <= pcnt + 1;
    if (!bus.lframe_n && bus.lad == 4'h0) cyc <= 5'h1;
    else if (cyc != 0 && cyc < 20) cyc <= cyc + 5'h1;
    else cyc <= 5'h0;
    if (cyc == 1) wk <= bus.lad[1];
    if (cyc >= 2 && cyc <= 9) wa <= {wa[27:0], bus.lad};
    if (cyc == 10 || cyc == 11 || cyc == 15 || cyc == 16)
      wd <= {bus.lad, wd[7:4]};
    // last data nibble taken live: the entry must exist before rsp_valid
    if ((!wk && cyc == 16) || (wk && cyc == 11))
      wq.push_back({wk, wa, bus.lad, wd[7:4]});
  end
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      chk(eq.size() != 0 && wq.size() != 0, "stray response");
      ew = eq.pop_front();
      gw = wq.pop_front();
      chk(gw === ew, "bus fields");
      chk(rsp_err === 1'b0 && (ew[40] || rsp_data === ew[7:0]), "rsp");
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // model updates at request time; responses come back in order
  task automatic push(input bit w, input logic [31:0] a,
                      input logic [7:0] d);
    int i;
    logic [7:0] x;
    x = d;
    if (w && pend) begin
      epc++;
      ea = a;
      ed = d;
      mode = 1;
      pend = 0;
    end else if (w) begin
      if (d == lfc_pkg::CMD_RD_ARRAY && !pe_busy) mode = 0;
      if (d == lfc_pkg::CMD_RD_STATUS) mode = 1;
      if (d == lfc_pkg::CMD_RD_SIG) mode = 2;
      if (d == lfc_pkg::CMD_PROG) pend = 1;
    end else if (mode == 0) x = a[7:0] ^ a[31:24];
    else x = (mode == 1) ? stat : (a[0] ? DEVC : MFR);
    eq.push_back({w, a, x});
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    for (i = 0; i < 400 && req_ready !== 1'b1; i++) begin
      refused = 1'b1;
      @(negedge clk);
    end
    if (i == 400) begin
      chk(1'b0, "request stuck");
      end_sim;
    end
    @(negedge clk);
  endtask
  task automatic drain(input string t);
    int i;
    req_valid = 1'b0;
    for (i = 0; i < 6000 && eq.size() != 0; i++) @(negedge clk);
    if (eq.size() != 0) begin
      chk(1'b0, "no response");
      end_sim;
    end
    repeat (4) @(negedge clk);
    $display("test %s done", t);
  endtask
  // one frame on the test bus; abort at cycle ab when ab is not zero
  task automatic bcyc(input logic [3:0] s, k, input int ab,
                      output int nd, output logic [3:0] sy);
    nd = 0;
    for (int c = 1; c <= 20; c++) begin
      @(negedge clk);
      if (bad.dev_lad_oe === 1'b1) nd++;
      if (c == 15) sy = bad.lad;
      bad.lframe_n = !(c == 1 || c == ab);
      bad.host_lad_oe = c <= (k[1] ? 13 : 11) || c == ab;
      bad.host_lad_o = c == 1 ? s : (c == 2 ? k : (c >= 11 ? 4'hf : 4'h0));
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    bad.lframe_n = 1'b1;
    bad.host_lad_oe = 1'b0;
    bad.host_lad_o = 4'h0;
    void'($urandom(32'hd6f5ac76));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    push(0, $urandom, 8'h00);
    drain("reset mode");
    push(1, $urandom, lfc_pkg::CMD_RD_SIG);
    push(0, 32'h0, 8'h00);
    push(0, 32'h1, 8'h00);
    drain("signature");
    stat = 8'($urandom);
    push(1, $urandom, lfc_pkg::CMD_RD_STATUS);
    push(0, $urandom, 8'h00);
    push(1, $urandom, 8'h00);
    push(0, $urandom, 8'h00);
    drain("status");
    push(1, $urandom, lfc_pkg::CMD_RD_ARRAY);
    push(0, $urandom, 8'h00);
    push(1, $urandom, lfc_pkg::CMD_PROG);
    push(1, $urandom, 8'($urandom));
    push(0, $urandom, 8'h00);
    drain("program");
    chk(pcnt === epc && prog_addr === ea && prog_data === ed, "prog");
    pe_busy = 1'b1;
    push(1, $urandom, lfc_pkg::CMD_RD_ARRAY);
    push(0, $urandom, 8'h00);
    drain("busy");
    pe_busy = 1'b0;
    push(1, $urandom, lfc_pkg::CMD_RD_ARRAY);
    push(0, $urandom, 8'h00);
    drain("array");
    refused = 1'b0;
    for (int j = 0; j < 12; j++) push(0, $urandom, 8'h00);
    chk(refused === 1'b1, "buffer never full");
    drain("buffer");
    for (int j = 0; j < 6; j++) begin
      bcyc(bs[j], bk[j], ba[j], drv, n15);
      chk(drv == bn[j], "drive count");
      if (j == 4) chk(n15 === 4'h0, "write sync");
    end
    $display("test lone target done");
    end_sim;
  end
endmodule
